// ### core/aimux_consts.svh
// Register offsets, field positions and reset values of the input mux block
`ifndef AIMUX_CONSTS_SVH
`define AIMUX_CONSTS_SVH
`define AIMUX_ADDR_CHSEL 8'hbb
`define AIMUX_ADDR_PINEN 8'hbd
`define AIMUX_CHSEL_RST 4'h0
`define AIMUX_PINEN_RST 8'h00
`define AIMUX_CHSEL_PAD 4'h0
`define AIMUX_CFG_P01 0
`define AIMUX_CFG_P23 1
`define AIMUX_CFG_HV 2
`define AIMUX_CFG_P3 3
`define AIMUX_CODE_AIN0 4'h0
`define AIMUX_CODE_AIN1 4'h1
`define AIMUX_CODE_AIN2 4'h2
`define AIMUX_CODE_AIN3 4'h3
`define AIMUX_CODE_HV 4'h4
`define AIMUX_CODE_GND 4'h5
`define AIMUX_CODE_EVEN 4'h6
`define AIMUX_CODE_ODD 4'h7
`define AIMUX_CODE_TEMP_BIT 3
`endif

// ### core/aimux_pkg.sv
// Types shared by the input mux block
package aimux_pkg;
  typedef enum logic [3:0] {
    AIMUX_SRC_NONE,
    AIMUX_SRC_AIN0,
    AIMUX_SRC_AIN1,
    AIMUX_SRC_AIN2,
    AIMUX_SRC_AIN3,
    AIMUX_SRC_HV,
    AIMUX_SRC_GND,
    AIMUX_SRC_EVEN,
    AIMUX_SRC_ODD,
    AIMUX_SRC_TEMP,
    AIMUX_SRC_HIGHVOLT_COMMON_REFERENCE
  } aimux_src_t;
endpackage

// ### core/aimux_sel_if.sv
// Decoded switch selection passed from decoder to top
`timescale 1ns/1ns
interface aimux_sel_if;
  import aimux_pkg::*;
  aimux_src_t pos_src;
  aimux_src_t neg_src;
  logic diff;
  modport dec (output pos_src, output neg_src, output diff);
  modport top (input pos_src, input neg_src, input diff);
endinterface

// ### core/aimux_decode.sv
// Channel address and pair configuration decoder
`timescale 1ns/1ns
`include "aimux_consts.svh"
module aimux_decode
  import aimux_pkg::*;
(
  input wire logic [3:0] chan_addr,
  input wire logic [3:0] pair_cfg,
  aimux_sel_if.dec sel
);
  always_comb begin
    sel.pos_src = AIMUX_SRC_NONE;
    sel.neg_src = AIMUX_SRC_NONE;
    sel.diff = 1'b0;
    if (chan_addr[`AIMUX_CODE_TEMP_BIT]) begin
      sel.pos_src = AIMUX_SRC_TEMP;
    end else begin
      unique case (chan_addr)
        `AIMUX_CODE_AIN0: begin
          sel.pos_src = AIMUX_SRC_AIN0;
          if (pair_cfg[`AIMUX_CFG_P01]) begin
            sel.neg_src = AIMUX_SRC_AIN1;
            sel.diff = 1'b1;
          end
        end
        `AIMUX_CODE_AIN1: begin
          if (!pair_cfg[`AIMUX_CFG_P01]) sel.pos_src = AIMUX_SRC_AIN1;
        end
        `AIMUX_CODE_AIN2: begin
          sel.pos_src = AIMUX_SRC_AIN2;
          if (pair_cfg[`AIMUX_CFG_P23]) begin
            sel.neg_src = AIMUX_SRC_AIN3;
            sel.diff = 1'b1;
          end
        end
        `AIMUX_CODE_AIN3: begin
          if (!pair_cfg[`AIMUX_CFG_P23]) sel.pos_src = AIMUX_SRC_AIN3;
        end
        `AIMUX_CODE_HV: begin
          sel.pos_src = AIMUX_SRC_HV;
          if (pair_cfg[`AIMUX_CFG_HV]) begin
            sel.neg_src = AIMUX_SRC_HIGHVOLT_COMMON_REFERENCE;
            sel.diff = 1'b1;
          end
        end
        `AIMUX_CODE_GND: begin
          if (!pair_cfg[`AIMUX_CFG_HV]) sel.pos_src = AIMUX_SRC_GND;
        end
        `AIMUX_CODE_EVEN: begin
          sel.pos_src = AIMUX_SRC_EVEN;
          if (pair_cfg[`AIMUX_CFG_P3]) begin
            sel.neg_src = AIMUX_SRC_ODD;
            sel.diff = 1'b1;
          end
        end
        `AIMUX_CODE_ODD: begin
          if (!pair_cfg[`AIMUX_CFG_P3]) sel.pos_src = AIMUX_SRC_ODD;
        end
        default: begin
          sel.pos_src = AIMUX_SRC_NONE;
        end
      endcase
    end
  end
endmodule // aimux_decode

// ### core/aimux_top.sv
// Analog input mux select: registers, decode and switch drive
`timescale 1ns/1ns
`include "aimux_consts.svh"
module aimux_top
  import aimux_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] input_pair_config,
  output logic [PINS-1:0] port3_analog_pin_enable,
  output logic [PINS-1:0] even_pin_switch,
  output logic [PINS-1:0] odd_pin_switch,
  output logic [10:0] pos_switch,
  output logic [10:0] neg_switch,
  output logic twos_complement
);
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] chsel_ff, nxt_chsel;
  logic [PINS-1:0] pinen_ff, nxt_pinen;
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_chsel = chsel_ff;
    nxt_pinen = pinen_ff;
    nxt_rdata = rdata_ff;
    if (sfr_wr && sfr_addr == `AIMUX_ADDR_CHSEL)
      nxt_chsel = sfr_wdata[3:0];
    if (sfr_wr && sfr_addr == `AIMUX_ADDR_PINEN)
      nxt_pinen = sfr_wdata[PINS-1:0];
    if (sfr_rd) begin
      unique case (sfr_addr)
        `AIMUX_ADDR_CHSEL: nxt_rdata = {`AIMUX_CHSEL_PAD, chsel_ff};
        `AIMUX_ADDR_PINEN: nxt_rdata = 8'(pinen_ff);
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      chsel_ff <= `AIMUX_CHSEL_RST;
      pinen_ff <= PINS'(`AIMUX_PINEN_RST);
      rdata_ff <= 8'h00;
    end else begin
      chsel_ff <= nxt_chsel;
      pinen_ff <= nxt_pinen;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign port3_analog_pin_enable = pinen_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode is combinational so the switches follow the register at once
  aimux_sel_if sel ();
  aimux_decode u_dec (
    .chan_addr(chsel_ff),
    .pair_cfg(input_pair_config),
    .sel(sel)
  );

  // Pins only reach the group when both enabled and the group is in use;
  // all enabled same-parity pins close together, giving the wired-OR
  logic even_used, odd_used;
  assign even_used = sel.pos_src == AIMUX_SRC_EVEN;
  assign odd_used = sel.pos_src == AIMUX_SRC_ODD ||
                    sel.neg_src == AIMUX_SRC_ODD;
  genvar g;
  for (g = 0; g < PINS; g++) begin : g_pin
    if (g % 2 == 0) begin : g_even
      assign even_pin_switch[g] = pinen_ff[g] & even_used;
      assign odd_pin_switch[g] = 1'b0;
    end else begin : g_odd
      assign even_pin_switch[g] = 1'b0;
      assign odd_pin_switch[g] = pinen_ff[g] & odd_used;
    end
  end

  // One-hot switch drive, index is the source code; none opens everything
  always_comb begin
    pos_switch = '0;
    neg_switch = '0;
    if (sel.pos_src != AIMUX_SRC_NONE)
      pos_switch[sel.pos_src] = 1'b1;
    if (sel.neg_src != AIMUX_SRC_NONE)
      neg_switch[sel.neg_src] = 1'b1;
  end
  assign twos_complement = sel.diff;

  ////////////////////////////////////////////////////////////////////////////
  // Register file: writes, readback and reset
  chsel_hi_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    sfr_rd && sfr_addr == `AIMUX_ADDR_CHSEL |=>
      sfr_rdata[7:4] == `AIMUX_CHSEL_PAD)
    else $error("channel select upper bits not zero");

  chsel_wr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    sfr_wr && sfr_addr == `AIMUX_ADDR_CHSEL |=>
      chsel_ff == $past(sfr_wdata[3:0]))
    else $error("channel select write lost");

  // No disable: these watch the edge right after a reset edge
  chsel_rst_a: assert property (
    @(posedge clk_sys)
    !rstn |=> chsel_ff == `AIMUX_CHSEL_RST)
    else $error("channel select not cleared by reset");

  pinen_rst_a: assert property (
    @(posedge clk_sys)
    !rstn |=> pinen_ff == PINS'(`AIMUX_PINEN_RST))
    else $error("pin enable not cleared by reset");

  pinen_wr_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    sfr_wr && sfr_addr == `AIMUX_ADDR_PINEN |=>
      port3_analog_pin_enable == $past(sfr_wdata[PINS-1:0]))
    else $error("pin enable write lost");

  pinen_rd_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    sfr_wr && sfr_addr == `AIMUX_ADDR_PINEN ##1
      sfr_rd && sfr_addr == `AIMUX_ADDR_PINEN && !sfr_wr
      |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("pin enable readback wrong");

  // Read data must stand until the next read strobe
  rdata_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  // Decode: single-ended codes and the temperature sensor
  temp_sel_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff[`AIMUX_CODE_TEMP_BIT] |->
      pos_switch[AIMUX_SRC_TEMP] && neg_switch == '0 && !twos_complement)
    else $error("temperature code not decoded");

  ain0_se_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_AIN0 && !input_pair_config[`AIMUX_CFG_P01] |->
      pos_switch[AIMUX_SRC_AIN0] && neg_switch == '0)
    else $error("input 0 single-ended not decoded");

  gnd_se_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_GND && !input_pair_config[`AIMUX_CFG_HV] |->
      pos_switch[AIMUX_SRC_GND] && neg_switch == '0)
    else $error("ground code not decoded");

  odd_se_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_ODD && !input_pair_config[`AIMUX_CFG_P3] |->
      pos_switch[AIMUX_SRC_ODD] && !twos_complement)
    else $error("odd group code not decoded");

  one_hot_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $onehot0(pos_switch) && $onehot0(neg_switch))
    else $error("more than one switch closed on a node");

  // Decode: differential pairs and the odd code that goes dead
  pair01_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_AIN1 && input_pair_config[`AIMUX_CFG_P01] |->
      pos_switch == '0 && neg_switch == '0)
    else $error("odd code of pair not open");

  pair23_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_AIN3 && input_pair_config[`AIMUX_CFG_P23] |->
      pos_switch == '0 && neg_switch == '0)
    else $error("odd code of second pair not open");

  diff01_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_AIN0 && input_pair_config[`AIMUX_CFG_P01] |->
      pos_switch[AIMUX_SRC_AIN0] && neg_switch[AIMUX_SRC_AIN1])
    else $error("first pair not differential");

  diff23_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_AIN2 && input_pair_config[`AIMUX_CFG_P23] |->
      pos_switch[AIMUX_SRC_AIN2] && neg_switch[AIMUX_SRC_AIN3] &&
      twos_complement)
    else $error("second pair bit not honoured");

  // Port 3 groups: pins close only while their group is in use
  even_pin_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_EVEN |->
      even_pin_switch == (pinen_ff & {(PINS/2){2'b01}}))
    else $error("even pins not routed");

  odd_pin_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_ODD && !input_pair_config[`AIMUX_CFG_P3] |->
      odd_pin_switch == (pinen_ff & {(PINS/2){2'b10}}))
    else $error("odd pins not routed");

  pin_idle_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff != `AIMUX_CODE_EVEN |-> even_pin_switch == '0)
    else $error("even pins closed while group unused");

  p3_diff_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_EVEN && input_pair_config[`AIMUX_CFG_P3] |->
      odd_pin_switch == (pinen_ff & {(PINS/2){2'b10}}) &&
      neg_switch[AIMUX_SRC_ODD])
    else $error("odd pins not on negative side");

  p3_pair_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_ODD && input_pair_config[`AIMUX_CFG_P3] |->
      odd_pin_switch == '0 && pos_switch == '0)
    else $error("paired odd group code not open");

  // Amplifier routing and result format
  hv_diff_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_HV |-> pos_switch[AIMUX_SRC_HV] &&
      neg_switch[AIMUX_SRC_HIGHVOLT_COMMON_REFERENCE] == input_pair_config[`AIMUX_CFG_HV])
    else $error("amplifier routing wrong");

  hv_pair_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    chsel_ff == `AIMUX_CODE_HV && input_pair_config[`AIMUX_CFG_HV] |->
      twos_complement)
    else $error("amplifier pair bit not honoured");

  twos_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    twos_complement |-> neg_switch != '0)
    else $error("two's complement without pair");

  twos_need_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    neg_switch != '0 |-> twos_complement)
    else $error("pair without two's complement");

  none_open_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    pos_switch == '0 |-> neg_switch == '0 && even_pin_switch == '0 &&
      odd_pin_switch == '0 && !twos_complement)
    else $error("switch closed while nothing selected");
endmodule // aimux_top

// ### tb/aimux_swmod.sv
// Behavioural switch matrix standing behind the mux select outputs
`timescale 1ns/1ns
module aimux_swmod (
  input wire logic [10:0] pos_switch,
  input wire logic [10:0] neg_switch,
  input wire logic [7:0] even_pin_switch,
  input wire logic [7:0] odd_pin_switch,
  output logic fault
);
  // Same-parity pins may share a node, cross-parity may not
  logic wrong_parity;
  assign wrong_parity = |(even_pin_switch & 8'haa) |
      |(odd_pin_switch & 8'h55);
  // Two closed switches on one node would short two sources
  assign fault = ($countones(pos_switch) > 1) ||
      ($countones(neg_switch) > 1) || wrong_parity;
endmodule // aimux_swmod

// ### tb/testbench.sv
// Self-checking bench for the analog input mux select block
`timescale 1ns/1ns
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
  n_errors++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module testbench;
  import aimux_pkg::*;
  logic clk_sys = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd_v;
  logic [7:0] pin_en, even_sw, odd_sw;
  logic [3:0] pair_cfg = 4'h0;
  logic [7:0] pin_set = 8'ha5;
  logic [10:0] pos_sw, neg_sw;
  logic twos, fault;
  int n_errors = 0;
  int tests_run = 0;
  always #20 clk_sys = ~clk_sys;
  aimux_top dut (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .input_pair_config(pair_cfg),
    .port3_analog_pin_enable(pin_en), .even_pin_switch(even_sw),
    .odd_pin_switch(odd_sw), .pos_switch(pos_sw), .neg_switch(neg_sw),
    .twos_complement(twos));
  aimux_swmod partner (.pos_switch(pos_sw), .neg_switch(neg_sw),
    .even_pin_switch(even_sw), .odd_pin_switch(odd_sw), .fault(fault));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  // Write then read in the very next cycle, no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    v = sfr_rdata;
  endtask
  // Junk in the upper nibble also exercises the dropped bits
  task automatic chk_sel(input logic [3:0] c, input logic [3:0] f);
    logic [10:0] p;
    logic [10:0] n;
    logic d;
    p = 11'h000;
    n = 11'h000;
    d = !c[3] && f[c[2:1]] && !c[0];
    pair_cfg = f;
    wr(8'hbb, {4'ha, c});
    if (c[3]) p[9] = 1'b1;
    else if (!f[c[2:1]]) p[c + 1] = 1'b1;
    else if (d) begin
      p[c + 1] = 1'b1;
      n[(c == 4'h4) ? 10 : c + 2] = 1'b1;
    end
    `CHK("pos", p, pos_sw)
    `CHK("neg", n, neg_sw)
    `CHK("twos", d, twos)
    `CHK("even", p[7] ? pin_set & 8'h55 : 8'h00, even_sw)
    `CHK("odd", (p[8] | n[8]) ? pin_set & 8'haa : 8'h00, odd_sw)
    `CHK("short", 1'b0, fault)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    `CHK("pos_rst", 11'h002, pos_sw)
    rd(8'hbb, rd_v);
    `CHK("chsel_rst", 8'h00, rd_v)
    rd(8'hbd, rd_v);
    `CHK("pinen_rst", 8'h00, rd_v)
    wr(8'hbd, pin_set);
    wr(8'hbc, 8'hff);
    rd(8'hbd, rd_v);
    `CHK("pinen", pin_set, rd_v)
    `CHK("pinen_port", pin_set, pin_en)
    rd(8'hbc, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    for (int f = 0; f < 16; f += 5)
      for (int c = 0; c < 16; c++) chk_sel(c[3:0], f[3:0]);
    rd(8'hbb, rd_v);
    `CHK("chsel_pad", 8'h0f, rd_v)
    // Back-to-back write and read, then the groups with a new mask
    pin_set = 8'h5a;
    wr_rd(8'hbd, pin_set, rd_v);
    `CHK("pinen_b2b", pin_set, rd_v)
    chk_sel(4'h6, 4'h8);
    chk_sel(4'h6, 4'h0);
    chk_sel(4'h7, 4'h0);
    // Reset in mid-run must clear both registers again
    rstn = 1'b0;
    @(negedge clk_sys);
    rstn = 1'b1;
    `CHK("pos_rst2", 11'h002, pos_sw)
    `CHK("pinen_port2", 8'h00, pin_en)
    rd(8'hbb, rd_v);
    `CHK("chsel_rst2", 8'h00, rd_v)
    complete_run();
  end
endmodule // testbench
